// >>> mlu_pkg.sv
// mlu_pkg: shared constants and carriers of the memory load unit
`default_nettype none
package mlu_pkg;
  // ************************************************************
  // instruction encodings
  // ************************************************************
  localparam logic [5:0] OPC_LOAD_DOUBLE_RIGHT_PART = 6'h1B;
  localparam logic [5:0] OPC_SIGNED_HALF_LOAD = 6'h21;
  localparam logic [5:0] OPC_UNSIGNED_HALF_LOAD = 6'h25;
  localparam logic [5:0] OPC_LINKED_WORD_LOAD = 6'h30;
  localparam logic [5:0] OPC_LINKED_DOUBLE_LOAD = 6'h34;
  localparam logic [5:0] OPC_FP_EXTENDED_OPCODE_GROUP = 6'h13;
  localparam logic [5:0] FN_INDEXED_FP_DOUBLE_LOAD = 6'h01;
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;
  localparam int TARGET_REGISTER_FIELD_MSB = 20;
  localparam int TARGET_REGISTER_FIELD_LSB = 16;
  localparam int FP_DESTINATION_FIELD_MSB = 10;
  localparam int FP_DESTINATION_FIELD_LSB = 6;
  localparam int OFFSET_MSB = 15;

  // ************************************************************
  // internal operation kinds
  // ************************************************************
  localparam logic [2:0] OPK_NONE = 3'h0;
  localparam logic [2:0] OPK_RIGHT = 3'h1;
  localparam logic [2:0] OPK_HALF_S = 3'h2;
  localparam logic [2:0] OPK_HALF_U = 3'h3;
  localparam logic [2:0] OPK_LLW = 3'h4;
  localparam logic [2:0] OPK_LDBL = 3'h5;
  localparam logic [2:0] OPK_FPX = 3'h6;

  // ************************************************************
  // exception codes and access sizes
  // ************************************************************
  localparam logic [2:0] EXC_NONE = 3'h0;
  localparam logic [2:0] EXC_ADDR = 3'h1;
  localparam logic [2:0] EXC_RESV = 3'h2;
  localparam logic [2:0] EXC_COPU = 3'h3;
  localparam logic [2:0] EXC_TLB_REFILL = 3'h4;
  localparam logic [2:0] EXC_TLB_INVALID = 3'h5;
  localparam logic [2:0] EXC_WATCH = 3'h6;
  localparam logic [2:0] EXC_BUS = 3'h7;
  localparam logic [1:0] SZ_PARTIAL = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_DOUBLE = 2'h3;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LINK_CLEAR = 8'h08;
  localparam logic [7:0] OFS_BAD_ADDR_LO = 8'h0C;
  localparam logic [7:0] OFS_BAD_ADDR_HI = 8'h10;
  localparam logic [7:0] OFS_LINK_ADDR_LO = 8'h14;
  localparam logic [7:0] OFS_LINK_ADDR_HI = 8'h18;
  localparam int CTRL_MEM_BE_BIT = 0;
  localparam int CTRL_CPU_BE_BIT = 1;
  localparam int CTRL_REV_BIT = 2;
  localparam int CTRL_FP_EN_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam int ST_LINK_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_EXC_LSB = 4;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic [63:0] addr;
    logic [1:0] size;
  } mlu_memreq_t;
  typedef struct packed {
    logic valid;
    logic [63:0] data;
    logic tlbRefill;
    logic tlbInvalid;
    logic watch;
    logic busErr;
  } mlu_memrsp_t;
  typedef struct packed {
    logic valid;
    logic toFp;
    logic [4:0] regIdx;
    logic [63:0] data;
  } mlu_wb_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } mlu_state_t;
endpackage
`default_nettype wire

// >>> memory_load_unit.sv
// memory_load_unit: load execution, alignment checks, lane select and link flag
`timescale 1ns/10ps
`default_nettype none
module memory_load_unit #(
  parameter int APB_AW = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic issueValid,
  input wire logic [31:0] issueInstr,
  input wire logic [63:0] baseVal,
  input wire logic [63:0] indexVal,
  input wire logic [63:0] targetVal,
  output logic issueReady,
  output mlu_pkg::mlu_memreq_t memReq,
  input wire mlu_pkg::mlu_memrsp_t memRsp,
  output mlu_pkg::mlu_wb_t wbOut,
  output logic excValid,
  output logic [2:0] excCode,
  output logic linkFlag,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ************************************************************
  // functions
  // ************************************************************
  // lane flip mask per kind, used for both the physical and lane xor
  function automatic logic [2:0] laneFlip(input logic [2:0] kind, input logic flag);
    logic [2:0] m;
    m = 3'h0;
    if (kind == mlu_pkg::OPK_RIGHT) begin
      m = {3{flag}};
    end else if (kind == mlu_pkg::OPK_HALF_S || kind == mlu_pkg::OPK_HALF_U) begin
      m = {flag, flag, 1'b0};
    end else if (kind == mlu_pkg::OPK_LLW) begin
      m = {flag, 2'b00};
    end
    return m;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  mlu_pkg::mlu_state_t stateReg, stateNext;
  logic [3:0] ctrlReg;
  logic [2:0] kindReg, byteReg;
  logic [63:0] targetReg, badAddrReg, linkAddrReg, vaReg;
  logic [4:0] destReg;
  logic linkNext;

  // ************************************************************
  // decode of the issued instruction
  // ************************************************************
  wire [5:0] opField = issueInstr[mlu_pkg::OPC_MSB:mlu_pkg::OPC_LSB];
  wire [5:0] fnField = issueInstr[5:0];
  wire isFpx = (opField == mlu_pkg::OPC_FP_EXTENDED_OPCODE_GROUP) &&
               (fnField == mlu_pkg::FN_INDEXED_FP_DOUBLE_LOAD);
  wire [2:0] kindDec =
    (opField == mlu_pkg::OPC_LOAD_DOUBLE_RIGHT_PART) ? mlu_pkg::OPK_RIGHT :
    (opField == mlu_pkg::OPC_SIGNED_HALF_LOAD) ? mlu_pkg::OPK_HALF_S :
    (opField == mlu_pkg::OPC_UNSIGNED_HALF_LOAD) ? mlu_pkg::OPK_HALF_U :
    (opField == mlu_pkg::OPC_LINKED_WORD_LOAD) ? mlu_pkg::OPK_LLW :
    (opField == mlu_pkg::OPC_LINKED_DOUBLE_LOAD) ? mlu_pkg::OPK_LDBL :
    isFpx ? mlu_pkg::OPK_FPX : mlu_pkg::OPK_NONE;
  wire memBe = ctrlReg[mlu_pkg::CTRL_MEM_BE_BIT];
  wire cpuBe = ctrlReg[mlu_pkg::CTRL_CPU_BE_BIT];
  wire revEnd = ctrlReg[mlu_pkg::CTRL_REV_BIT];
  wire fpEn = ctrlReg[mlu_pkg::CTRL_FP_EN_BIT];

  // effective address
  wire [63:0] offsetExt = {{48{issueInstr[mlu_pkg::OFFSET_MSB]}}, issueInstr[15:0]};
  wire [63:0] fpxSum = baseVal + indexVal;
  wire [63:0] offSum = baseVal + offsetExt;
  wire [63:0] vaNext = isFpx ? fpxSum : offSum;

  // alignment: doubles need three clear bits, words two, halves one
  // fp double and linked double alignment
  wire misDouble = (vaNext[2:0] != 3'h0);
  wire misAlign =
    ((kindDec == mlu_pkg::OPK_FPX || kindDec == mlu_pkg::OPK_LDBL) && misDouble) ||
    (kindDec == mlu_pkg::OPK_LLW && vaNext[1:0] != 2'h0) ||
    ((kindDec == mlu_pkg::OPK_HALF_S || kindDec == mlu_pkg::OPK_HALF_U) && vaNext[0]);
  wire [2:0] decExc =
    (kindDec == mlu_pkg::OPK_NONE) ? mlu_pkg::EXC_RESV :
    (isFpx && !fpEn) ? mlu_pkg::EXC_COPU :
    misAlign ? mlu_pkg::EXC_ADDR : mlu_pkg::EXC_NONE;

  // physical low bits and lane select
  // reverse-endian flip
  wire [2:0] pFlip = vaNext[2:0] ^ laneFlip(kindDec, revEnd);
  wire [2:0] pLow = (kindDec == mlu_pkg::OPK_RIGHT && memBe) ? 3'h0 : pFlip;
  wire [2:0] byteNext = vaNext[2:0] ^ laneFlip(kindDec, cpuBe);
  wire [1:0] sizeNext =
    (kindDec == mlu_pkg::OPK_RIGHT) ? mlu_pkg::SZ_PARTIAL :
    (kindDec == mlu_pkg::OPK_HALF_S || kindDec == mlu_pkg::OPK_HALF_U) ? mlu_pkg::SZ_HALF :
    (kindDec == mlu_pkg::OPK_LLW) ? mlu_pkg::SZ_WORD : mlu_pkg::SZ_DOUBLE;
  wire [4:0] destNext = isFpx ?
    issueInstr[mlu_pkg::FP_DESTINATION_FIELD_MSB:mlu_pkg::FP_DESTINATION_FIELD_LSB] :
    issueInstr[mlu_pkg::TARGET_REGISTER_FIELD_MSB:mlu_pkg::TARGET_REGISTER_FIELD_LSB];
  wire accept = (stateReg == mlu_pkg::ST_IDLE) && issueValid;
  wire acceptOk = accept && (decExc == mlu_pkg::EXC_NONE);
  wire acceptBad = accept && (decExc != mlu_pkg::EXC_NONE);

  // ************************************************************
  // response shaping
  // ************************************************************
  wire rspDone = (stateReg == mlu_pkg::ST_WAIT) && memRsp.valid;
  wire [2:0] rspExc =
    memRsp.tlbRefill ? mlu_pkg::EXC_TLB_REFILL :
    memRsp.tlbInvalid ? mlu_pkg::EXC_TLB_INVALID :
    memRsp.watch ? mlu_pkg::EXC_WATCH :
    memRsp.busErr ? mlu_pkg::EXC_BUS : mlu_pkg::EXC_NONE;
  wire rspOk = rspDone && (rspExc == mlu_pkg::EXC_NONE);
  wire [5:0] shAmt = {byteReg, 3'b000};
  wire [63:0] memShift = memRsp.data >> shAmt;
  // keep upper 8*byte bits of the target
  wire [63:0] keepMask = ~(64'hFFFF_FFFF_FFFF_FFFF >> shAmt);
  wire [63:0] rightData = (targetReg & keepMask) | memShift;
  wire [63:0] halfSData = {{48{memShift[15]}}, memShift[15:0]};
  wire [63:0] halfUData = {48'h0, memShift[15:0]};
  wire [63:0] llwData = {{32{memShift[31]}}, memShift[31:0]};
  wire [63:0] resData =
    (kindReg == mlu_pkg::OPK_RIGHT) ? rightData :
    (kindReg == mlu_pkg::OPK_HALF_S) ? halfSData :
    (kindReg == mlu_pkg::OPK_HALF_U) ? halfUData :
    (kindReg == mlu_pkg::OPK_LLW) ? llwData : memRsp.data;
  // both linked loads set the flag
  wire linkSet = rspOk && (kindReg == mlu_pkg::OPK_LLW || kindReg == mlu_pkg::OPK_LDBL);

  // ************************************************************
  // apb decode
  // ************************************************************
  wire apbSetup = psel && !penable;
  wire apbAccess = psel && penable && pready;
  wire [7:0] regOfs = 8'(paddr);
  wire hitCtrl = (regOfs == mlu_pkg::OFS_CTRL);
  wire hitClr = (regOfs == mlu_pkg::OFS_LINK_CLEAR);
  wire wrCtrl = apbAccess && pwrite && hitCtrl;
  wire linkClr = apbAccess && pwrite && hitClr && pwdata[0];
  wire [31:0] statusWord = {25'h0, excCode, 2'b00, (stateReg == mlu_pkg::ST_WAIT), linkFlag};
  wire mapped = hitCtrl || hitClr || (regOfs == mlu_pkg::OFS_STATUS) ||
                (regOfs == mlu_pkg::OFS_BAD_ADDR_LO) || (regOfs == mlu_pkg::OFS_BAD_ADDR_HI) ||
                (regOfs == mlu_pkg::OFS_LINK_ADDR_LO) || (regOfs == mlu_pkg::OFS_LINK_ADDR_HI);
  wire roWrite = pwrite && mapped && !hitCtrl && !hitClr;
  wire [31:0] rdMux =
    hitCtrl ? {28'h0, ctrlReg} :
    (regOfs == mlu_pkg::OFS_STATUS) ? statusWord :
    (regOfs == mlu_pkg::OFS_BAD_ADDR_LO) ? badAddrReg[31:0] :
    (regOfs == mlu_pkg::OFS_BAD_ADDR_HI) ? badAddrReg[63:32] :
    (regOfs == mlu_pkg::OFS_LINK_ADDR_LO) ? linkAddrReg[31:0] :
    (regOfs == mlu_pkg::OFS_LINK_ADDR_HI) ? linkAddrReg[63:32] : 32'h0;

  // ************************************************************
  // control sequence
  // ************************************************************
  // next state: a bad decode stays idle, a good one waits for memory
  always_comb begin
    stateNext = stateReg;
    unique case (stateReg)
      mlu_pkg::ST_IDLE: begin
        if (acceptOk) begin
          stateNext = mlu_pkg::ST_WAIT;
        end
      end
      mlu_pkg::ST_WAIT: begin
        if (memRsp.valid) begin
          stateNext = mlu_pkg::ST_IDLE;
        end
      end
      default: stateNext = mlu_pkg::ST_IDLE;
    endcase
  end

  // state and ready; ready drops the cycle after a good accept
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stateReg <= mlu_pkg::ST_IDLE;
      issueReady <= 1'b0;
    end else begin
      stateReg <= stateNext;
      issueReady <= (stateNext == mlu_pkg::ST_IDLE);
    end
  end

  // captured operands of the load in flight
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      kindReg <= mlu_pkg::OPK_NONE;
      byteReg <= 3'h0;
      targetReg <= 64'h0;
      destReg <= 5'h0;
      vaReg <= 64'h0;
    end else if (acceptOk) begin
      kindReg <= kindDec;
      byteReg <= byteNext;
      targetReg <= targetVal;
      destReg <= destNext;
      vaReg <= vaNext;
    end
  end

  // memory request held until the response arrives
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      memReq <= '0;
    end else if (acceptOk) begin
      memReq <= '{valid: 1'b1, addr: {vaNext[63:3], pLow}, size: sizeNext};
    end else if (rspDone) begin
      memReq.valid <= 1'b0;
    end
  end

  // write back only on a clean response
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wbOut <= '0;
    end else begin
      wbOut <= '{valid: rspOk, toFp: (kindReg == mlu_pkg::OPK_FPX),
                 regIdx: destReg, data: resData};
    end
  end

  // exception pulse; code and faulting address stay for software
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      excValid <= 1'b0;
      excCode <= mlu_pkg::EXC_NONE;
      badAddrReg <= 64'h0;
    end else begin
      excValid <= acceptBad || (rspDone && !rspOk);
      if (acceptBad) begin
        excCode <= decExc;
        badAddrReg <= vaNext;
      end else if (rspDone && !rspOk) begin
        excCode <= rspExc;
        badAddrReg <= vaReg;
      end
    end
  end

  // one sequence, newest replaces the old
  // no outward action on a linked load
  // flag may stay set indefinitely
  // set wins over a software clear in the same cycle
  assign linkNext = linkSet ? 1'b1 : (linkClr ? 1'b0 : linkFlag);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      linkFlag <= 1'b0;
      linkAddrReg <= 64'h0;
    end else begin
      linkFlag <= linkNext;
      if (linkSet) begin
        linkAddrReg <= vaReg;
      end
    end
  end

  // apb: one wait-free access, answers registered in setup
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apbSetup;
      pslverr <= apbSetup && (!mapped || roWrite);
      prdata <= (apbSetup && !pwrite) ? rdMux : 32'h0;
    end
  end

  // control register: endian flags and fp enable
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrlReg <= mlu_pkg::CTRL_RESET;
    end else if (wrCtrl) begin
      ctrlReg <= pwdata[3:0];
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_MEM_BE_ALIGN: assert property (
    acceptOk && kindDec == mlu_pkg::OPK_RIGHT && memBe
      |=> memReq.valid && memReq.addr[2:0] == 3'h0)
    else $error("right-part load address not aligned");
  AST_FPX_SUM: assert property (
    acceptOk && isFpx |=> memReq.addr[63:3] == $past(fpxSum[63:3]))
    else $error("indexed fp address wrong");
  AST_FPX_ALIGN: assert property (
    accept && isFpx && fpEn && vaNext[2:0] != 3'h0 |=> excValid && excCode == mlu_pkg::EXC_ADDR
      && !memReq.valid)
    else $error("misaligned fp double not faulted");
  AST_HALF_ALIGN: assert property (
    accept && (kindDec == mlu_pkg::OPK_HALF_S || kindDec == mlu_pkg::OPK_HALF_U) && vaNext[0]
      |=> excValid && excCode == mlu_pkg::EXC_ADDR)
    else $error("odd halfword address not faulted");
  AST_LDBL_ALIGN: assert property (
    accept && kindDec == mlu_pkg::OPK_LDBL && vaNext[2:0] != 3'h0
      |=> excCode == mlu_pkg::EXC_ADDR)
    else $error("misaligned linked double not faulted");
  AST_HALF_SIGN: assert property (
    rspOk && kindReg == mlu_pkg::OPK_HALF_S
      |=> wbOut.valid && wbOut.data[63:16] == {48{wbOut.data[15]}})
    else $error("signed half not sign-extended");
  AST_HALF_ZERO: assert property (
    rspOk && kindReg == mlu_pkg::OPK_HALF_U |=> wbOut.valid && wbOut.data[63:16] == 48'h0)
    else $error("unsigned half not zero-extended");
  AST_LLW_LINK: assert property (
    rspOk && kindReg == mlu_pkg::OPK_LLW
      |=> linkFlag && wbOut.data[63:32] == {32{wbOut.data[31]}})
    else $error("linked word result or flag wrong");
  AST_LDBL_DATA: assert property (
    rspOk && kindReg == mlu_pkg::OPK_LDBL |=> wbOut.data == $past(memRsp.data) && linkFlag)
    else $error("linked double data changed");
  AST_FAULT_QUIET: assert property (
    acceptBad ##1 !$past(linkClr) |-> !wbOut.valid && linkFlag == $past(linkFlag))
    else $error("faulting load disturbed state");
  // response faults must leave the register file and the flag alone too
  AST_RSP_QUIET: assert property (
    rspDone && !rspOk && !linkClr
      |=> excValid && !wbOut.valid && linkFlag == $past(linkFlag))
    else $error("faulted response disturbed state");
  AST_WORD_ALIGN: assert property (
    accept && kindDec == mlu_pkg::OPK_LLW && vaNext[1:0] != 2'h0
      |=> excValid && excCode == mlu_pkg::EXC_ADDR && !memReq.valid)
    else $error("misaligned linked word not faulted");
  AST_FPX_DATA: assert property (
    rspOk && kindReg == mlu_pkg::OPK_FPX
      |=> wbOut.valid && wbOut.toFp && wbOut.data == $past(memRsp.data))
    else $error("fp double not written unchanged");
endmodule
`default_nettype wire

// >>> mlu_mem_model.sv
// mlu_mem_model: memory side that answers the load unit's requests
`timescale 1ns/10ps
`default_nettype none
module mlu_mem_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire mlu_pkg::mlu_memreq_t memReq,
  input wire logic [63:0] memWord,
  input wire logic [3:0] errSel,
  input wire logic [3:0] memDelay,
  output mlu_pkg::mlu_memrsp_t memRsp
);
  logic [3:0] waitCnt;
  logic sent;
  // one answer per request, memDelay+1 cycles after it rises; idle data and flags toggle
  // every cycle so a design that ignores the valid qualifier is caught
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      memRsp <= '0;
      waitCnt <= 4'h0;
      sent <= 1'b0;
    end else begin
      memRsp.valid <= 1'b0;
      memRsp.data <= ~memRsp.data;
      memRsp[3:0] <= ~memRsp[3:0];
      if (memReq.valid !== 1'b1) begin
        sent <= 1'b0;
        waitCnt <= 4'h0;
      end else if (!sent && waitCnt == memDelay) begin
        memRsp.valid <= 1'b1;
        memRsp.data <= memWord;
        memRsp[3:0] <= errSel;
        sent <= 1'b1;
      end else if (!sent) begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb_memory_load_unit.sv
// tb_memory_load_unit: directed loads and register accesses with checks
`timescale 1ns/10ps
`default_nettype none
module tb_memory_load_unit;
  logic clk_sys, reset, issueValid, psel, penable, pwrite, issueReady;
  logic excValid, linkFlag, pready, pslverr;
  logic [31:0] issueInstr, pwdata, prdata;
  logic [63:0] baseVal, indexVal, targetVal, memWord;
  logic [7:0] paddr;
  logic [3:0] errSel, memDelay, cfg;
  logic [2:0] excCode;
  mlu_pkg::mlu_memreq_t memReq;
  mlu_pkg::mlu_memrsp_t memRsp;
  mlu_pkg::mlu_wb_t wbOut;
  int errTotal, totalChecks, cycles;

  memory_load_unit #(.APB_AW(8)) u_memory_load_unit (.clk_sys, .reset, .issueValid,
    .issueInstr, .baseVal, .indexVal, .targetVal, .issueReady, .memReq, .memRsp, .wbOut,
    .excValid, .excCode, .linkFlag, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  mlu_mem_model u_mlu_mem_model (.clk_sys, .reset, .memReq, .memWord, .errSel,
    .memDelay, .memRsp);

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (errTotal == 0 && totalChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic expErr);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys) penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    check(pslverr, expErr);
    if (!wr) check(prdata, exp);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic setcfg(input logic [3:0] c);
    acc(1'b1, mlu_pkg::OFS_CTRL, {28'h0, c}, 32'h0, 1'b0);
    cfg = c;
  endtask

  function automatic logic [31:0] mk(input logic [5:0] op, input logic [4:0] tgt,
                                     input logic [15:0] off);
    return {op, 5'h03, tgt, off};
  endfunction

  // right-part merge expectation from the current endian setting
  function automatic logic [63:0] rightExp(input logic [2:0] va);
    logic [6:0] sh;
    sh = {1'b0, va ^ {3{cfg[1]}}, 3'b000};
    return (targetVal & ~(64'hFFFF_FFFF_FFFF_FFFF >> sh)) | (memWord >> sh);
  endfunction

  // issue one load, follow it to writeback or fault
  task automatic load(input logic [31:0] ins, input logic [63:0] b, input logic [63:0] x,
                      input logic [2:0] eExc, input logic [63:0] eAddr,
                      input logic [63:0] eData);
    logic seen;
    logic isFp;
    logic [63:0] addr;
    logic [1:0] sz;
    logic [1:0] expSz;
    seen = 1'b0;
    isFp = (ins[31:26] == mlu_pkg::OPC_FP_EXTENDED_OPCODE_GROUP);
    expSz = (ins[31:26] == mlu_pkg::OPC_LOAD_DOUBLE_RIGHT_PART) ? mlu_pkg::SZ_PARTIAL :
            (ins[31:26] == mlu_pkg::OPC_LINKED_WORD_LOAD) ? mlu_pkg::SZ_WORD :
            (ins[31:26] == mlu_pkg::OPC_SIGNED_HALF_LOAD ||
             ins[31:26] == mlu_pkg::OPC_UNSIGNED_HALF_LOAD) ? mlu_pkg::SZ_HALF :
            mlu_pkg::SZ_DOUBLE;
    @(posedge clk_sys);
    while (issueReady !== 1'b1) @(posedge clk_sys);
    issueValid <= 1'b1;
    issueInstr <= ins;
    baseVal <= b;
    indexVal <= x;
    @(posedge clk_sys) issueValid <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      #1;
      if (memReq.valid === 1'b1) begin
        seen = 1'b1;
        addr = memReq.addr;
        sz = memReq.size;
      end
      if (excValid === 1'b1 || wbOut.valid === 1'b1) break;
      @(posedge clk_sys);
    end
    check(excValid, eExc != mlu_pkg::EXC_NONE);
    if (eExc != mlu_pkg::EXC_NONE) begin
      check(excCode, eExc);
      check(wbOut.valid, 1'b0);
      check(seen, eExc >= mlu_pkg::EXC_TLB_REFILL);
    end else begin
      check(wbOut.data, eData);
      check(wbOut.toFp, isFp);
      check(wbOut.regIdx, isFp ? ins[10:6] : ins[20:16]);
      check(wbOut.valid, 1'b1);
      check(addr, eAddr);
      check(sz, expSz);
    end
  endtask

  // ************************************************************
  // clock, watchdog, sequence
  // ************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // a hang counts as a mismatch
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errTotal++;
      stop_test();
    end
  end

  initial begin
    {reset, issueValid, psel, penable, pwrite} = 5'b10000;
    {issueInstr, pwdata, paddr, errSel, memDelay, cfg} = '0;
    {baseVal, indexVal} = '0;
    targetVal = 64'h0123_4567_89AB_CDEF;
    memWord = 64'hF1E2_D3C4_B5A6_9788;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1 check(issueReady, 1'b1);
    check(linkFlag, 1'b0);
    acc(1'b0, mlu_pkg::OFS_CTRL, 32'h0, 32'h0, 1'b0);
    acc(1'b0, mlu_pkg::OFS_STATUS, 32'h0, 32'h0, 1'b0);
    acc(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
    acc(1'b1, mlu_pkg::OFS_STATUS, 32'h1, 32'h0, 1'b1);
    // every endian mix and lane offset, answers from prompt to slow
    for (int c = 0; c < 8; c++) begin
      setcfg(c[3:0]);
      memDelay <= c[3:0];
      load(mk(mlu_pkg::OPC_LOAD_DOUBLE_RIGHT_PART, 5'h07, 16'h0000), 64'h1000 + c, '0,
           mlu_pkg::EXC_NONE, {61'h200, (c[2:0] ^ {3{c[2]}}) & {3{~c[0]}}},
           rightExp(c[2:0]));
    end
    setcfg(4'h4);
    load(mk(mlu_pkg::OPC_SIGNED_HALF_LOAD, 5'h05, 16'hFFFA), 64'h2008, '0,
         mlu_pkg::EXC_NONE, 64'h2004, 64'hFFFF_FFFF_FFFF_B5A6);
    setcfg(4'h2);
    load(mk(mlu_pkg::OPC_UNSIGNED_HALF_LOAD, 5'h06, 16'h0002), 64'h2000, '0,
         mlu_pkg::EXC_NONE, 64'h2002, 64'h0000_0000_0000_D3C4);
    load(mk(mlu_pkg::OPC_SIGNED_HALF_LOAD, 5'h05, 16'h0000), 64'h2001, '0,
         mlu_pkg::EXC_ADDR, '0, '0);
    acc(1'b0, mlu_pkg::OFS_BAD_ADDR_LO, 32'h0, 32'h2001, 1'b0);
    acc(1'b0, mlu_pkg::OFS_BAD_ADDR_HI, 32'h0, 32'h0, 1'b0);
    setcfg(4'h4);
    // plain, synchronizable locations only
    load(mk(mlu_pkg::OPC_LINKED_WORD_LOAD, 5'h08, 16'h0004), 64'h3000, '0,
         mlu_pkg::EXC_NONE, 64'h3000, 64'hFFFF_FFFF_F1E2_D3C4);
    check(linkFlag, 1'b1);
    acc(1'b0, mlu_pkg::OFS_STATUS, 32'h0, 32'h11, 1'b0);
    acc(1'b1, mlu_pkg::OFS_LINK_CLEAR, 32'h1, 32'h0, 1'b0);
    #1 check(linkFlag, 1'b0);
    load(mk(mlu_pkg::OPC_LINKED_WORD_LOAD, 5'h08, 16'h0002), 64'h3000, '0,
         mlu_pkg::EXC_ADDR, '0, '0);
    check(linkFlag, 1'b0);
    load(mk(mlu_pkg::OPC_LINKED_DOUBLE_LOAD, 5'h09, 16'h0008), 64'h3000, '0,
         mlu_pkg::EXC_NONE, 64'h3008, memWord);
    check(linkFlag, 1'b1);
    acc(1'b0, mlu_pkg::OFS_LINK_ADDR_LO, 32'h0, 32'h3008, 1'b0);
    load(mk(mlu_pkg::OPC_LINKED_WORD_LOAD, 5'h08, 16'h0010), 64'h3000, '0,
         mlu_pkg::EXC_NONE, 64'h3014, 64'hFFFF_FFFF_B5A6_9788);
    acc(1'b0, mlu_pkg::OFS_LINK_ADDR_LO, 32'h0, 32'h3010, 1'b0);
    acc(1'b0, mlu_pkg::OFS_LINK_ADDR_HI, 32'h0, 32'h0, 1'b0);
    load(mk(mlu_pkg::OPC_LINKED_DOUBLE_LOAD, 5'h09, 16'h000C), 64'h3000, '0,
         mlu_pkg::EXC_ADDR, '0, '0);
    check(linkFlag, 1'b1);
    load(mk(mlu_pkg::OPC_FP_EXTENDED_OPCODE_GROUP, 5'h04, 16'h0241), 64'h4000, 64'h18,
         mlu_pkg::EXC_COPU, '0, '0);
    setcfg(4'hC);
    load(mk(mlu_pkg::OPC_FP_EXTENDED_OPCODE_GROUP, 5'h04, 16'h0241), 64'h4000, 64'h18,
         mlu_pkg::EXC_NONE, 64'h4018, memWord);
    load(mk(mlu_pkg::OPC_FP_EXTENDED_OPCODE_GROUP, 5'h04, 16'h0241), 64'h4000, 64'h1C,
         mlu_pkg::EXC_ADDR, '0, '0);
    load(mk(mlu_pkg::OPC_FP_EXTENDED_OPCODE_GROUP, 5'h04, 16'h0245), 64'h4000, 64'h18,
         mlu_pkg::EXC_RESV, '0, '0);
    load(mk(6'h3F, 5'h04, 16'h0000), 64'h4000, '0, mlu_pkg::EXC_RESV, '0, '0);
    acc(1'b1, mlu_pkg::OFS_LINK_CLEAR, 32'h1, 32'h0, 1'b0);
    // each memory fault alone, then all at once where refill wins
    for (int k = 0; k < 5; k++) begin
      errSel <= (k == 4) ? 4'hF : 4'h8 >> k;
      load(mk(mlu_pkg::OPC_LINKED_DOUBLE_LOAD, 5'h09, 16'h0000), 64'h5000, '0,
           (k == 4) ? 3'h4 : 3'h4 + k[2:0], '0, '0);
      check(linkFlag, 1'b0);
    end
    stop_test();
  end
endmodule
`default_nettype wire
